// ---- hdl/qeiu_pkg.sv ----
// How it works
// - Enabled events append to eight-entry FIFO queue.
// - Non-empty queue suspends main program execution.
// - Head event number is presented for dispatch.
// - Completion report removes head, shifts rest forward.
// - Dispatch continues until empty, then main resumes.
// - One request in service; no preemption.
// - Full queue masks events until drained.
// - Request needs own enable and global enable.
// - Unbound event is accepted, dequeued, no action.
// - Timers raise event each programmed millisecond interval.
// - Three timers raise events 26, 27, 28.
// - Timer enable changes leave queued requests alone.
// - Timer enable rising restarts elapsed count.
// - Input edges raise 0-7 rising, 10-17 falling.
// - Input edges serviced up to about 1 kHz.
// - Counter events 20-25, 40-41 share one enable.
// - Pulse-output completions raise 18, 19, 42-47.
// - Serial events use 30-37 and 8, 9, 38, 39.
// - Interpolation 50-52, passed-position 53-58, individually enabled.
// - Supply failure raises event 29, own enable.
package qeiu_pkg;

    // ------------------------------------------------------------------
    // Queue and event geometry
    // ------------------------------------------------------------------
    localparam int          QEIU_DEPTH     = 8;
    localparam int          QEIU_EV_W      = 6;
    localparam int          QEIU_EV_NUM    = 64;
    localparam int          QEIU_CNT_W     = 4;

    // ------------------------------------------------------------------
    // Event numbers
    // ------------------------------------------------------------------
    localparam int          EV_RISE_BASE   = 0;
    localparam int          EV_FALL_BASE   = 10;
    localparam int          EV_CNT_LO_BASE = 20;
    localparam int          EV_CNT_HI_BASE = 40;
    localparam int          EV_TIMER_BASE  = 26;
    localparam int          EV_SUPPLY      = 29;
    localparam int          EV_SER01_BASE  = 30;
    localparam int          EV_SER2_CHR    = 8;
    localparam int          EV_SER2_FRM    = 38;
    localparam int          EV_PULSE01     = 18;
    localparam int          EV_PULSE_HI    = 42;
    localparam int          EV_INTERP_BASE = 50;
    localparam int          EV_POS_BASE    = 53;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_MHZ        = 100;
    localparam int          TICK_US        = 1000;
    localparam int          TICK_CYCLES    = TICK_US * CLK_MHZ;
    localparam int          TMR_W          = 16;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_EN_INPUT   = 8'h04;
    localparam logic [7:0]  OFS_EN_MISC    = 8'h08;
    localparam logic [7:0]  OFS_EN_PULSE   = 8'h0c;
    localparam logic [7:0]  OFS_EN_SERIAL  = 8'h10;
    localparam logic [7:0]  OFS_EN_POS     = 8'h14;
    localparam logic [7:0]  OFS_TMR0       = 8'h18;
    localparam logic [7:0]  OFS_TMR1       = 8'h1c;
    localparam logic [7:0]  OFS_TMR2       = 8'h20;
    localparam logic [7:0]  OFS_HND_LO     = 8'h24;
    localparam logic [7:0]  OFS_HND_HI     = 8'h28;
    localparam logic [7:0]  OFS_STATUS     = 8'h2c;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          MISC_CNT_BIT   = 0;
    localparam int          MISC_TMR_BIT   = 1;
    localparam int          MISC_SUP_BIT   = 4;
    localparam int          POS_PASS_BIT   = 3;
    localparam int          ST_CNT_BIT     = 0;
    localparam int          ST_MASK_BIT    = 4;
    localparam int          ST_SUSP_BIT    = 5;
    localparam int          ST_HEAD_BIT    = 8;
    localparam logic [31:0] RST_ZERO       = 32'h0000_0000;

endpackage

// ---- hdl/qeiu_top.sv ----
`timescale 1ns/10ps
module qeiu_top
    import qeiu_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [7:0]           input_pins,
    input  wire logic [7:0]           counter_evt,
    input  wire logic [7:0]           pulse_train_output_done,
    input  wire logic [11:0]          serial_evt,
    input  wire logic [2:0]           interp_done,
    input  wire logic [5:0]           pass_pos_evt,
    input  wire logic                 supply_fail,
    input  wire logic                 handler_done,
    output logic                      main_suspend,
    output logic                      head_valid,
    output logic [QEIU_EV_W-1:0]      head_event,
    output logic                      head_has_handler
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic                         global_irq_enable_ff;
    logic [7:0]                   en_input_ff;
    logic [4:0]                   en_misc_ff;
    logic [7:0]                   en_pulse_ff;
    logic [11:0]                  en_serial_ff;
    logic [8:0]                   en_pos_ff;
    logic [TMR_W-1:0]             interval_ff [3];
    logic [63:0]                  handler_map_ff;

    logic [31:0]                  prdata_ff;

    logic [QEIU_EV_W-1:0]         queue_ff [QEIU_DEPTH];
    logic [QEIU_CNT_W-1:0]        count_ff;
    logic                         mask_ff;
    logic                         suspend_ff;

    logic [31:0]                  tick_cnt_ff;
    logic                         tick_ff;
    logic [7:0]                   pin_ff;
    logic [TMR_W-1:0]             elapsed_ff [3];
    logic [2:0]                   tmr_en_d_ff;
    logic [2:0]                   tmr_fire;

    logic                         wr_en;
    logic                         setup;
    logic                         mapped;

    logic [63:0]                  raw_evt;
    logic [63:0]                  evt_en;
    logic [63:0]                  pend;

    logic                         deq;
    logic [QEIU_EV_W-1:0]         nxt_queue [QEIU_DEPTH];
    logic [QEIU_CNT_W-1:0]        nxt_count;

    logic [31:0]                  status;

    logic [7:0]                   rise;
    logic [7:0]                   fall;

    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign prdata  = prdata_ff;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Unmapped offsets read zero and raise pslverr.
    always_comb begin
        unique case (paddr)
            OFS_CTRL,
            OFS_EN_INPUT,
            OFS_EN_MISC,
            OFS_EN_PULSE,
            OFS_EN_SERIAL,
            OFS_EN_POS,
            OFS_TMR0,
            OFS_TMR1,
            OFS_TMR2,
            OFS_HND_LO,
            OFS_HND_HI,
            OFS_STATUS: mapped = 1'b1;
            default:    mapped = 1'b0;
        endcase
    end

    // Writes to the read-only status word are flagged as well.
    assign pslverr = psel && penable
                     && (!mapped || (pwrite && paddr == OFS_STATUS));

    // ------------------------------------------------------------------
    // APB register writes
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_irq_enable_ff <= 1'b0;
            en_input_ff          <= RST_ZERO[7:0];
            en_misc_ff           <= RST_ZERO[4:0];
            en_pulse_ff          <= RST_ZERO[7:0];
            en_serial_ff         <= RST_ZERO[11:0];
            en_pos_ff            <= RST_ZERO[8:0];
            handler_map_ff       <= {RST_ZERO, RST_ZERO};
        end else if (wr_en) begin
            unique case (paddr)
                OFS_CTRL:      global_irq_enable_ff <= pwdata[0];
                OFS_EN_INPUT:  en_input_ff          <= pwdata[7:0];
                OFS_EN_MISC:   en_misc_ff           <= pwdata[4:0];
                OFS_EN_PULSE:  en_pulse_ff          <= pwdata[7:0];
                OFS_EN_SERIAL: en_serial_ff         <= pwdata[11:0];
                OFS_EN_POS:    en_pos_ff            <= pwdata[8:0];
                OFS_HND_LO:    handler_map_ff[31:0]  <= pwdata;
                OFS_HND_HI:    handler_map_ff[63:32] <= pwdata;
                default: ;
            endcase
        end
    end

    // Intervals are written while a timer is off; a live rewrite takes effect at the next tick.
    genvar t;

    generate
        for (t = 0; t < 3; t++) begin : g_ivl
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    interval_ff[t] <= RST_ZERO[TMR_W-1:0];
                end else if (wr_en && paddr == OFS_TMR0 + 8'(4 * t)) begin
                    interval_ff[t] <= pwdata[TMR_W-1:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // APB read data, captured in the setup cycle
    // ------------------------------------------------------------------
    always_comb begin
        status = RST_ZERO;
        status[ST_CNT_BIT +: QEIU_CNT_W] = count_ff;
        status[ST_MASK_BIT]              = mask_ff;
        status[ST_SUSP_BIT]              = suspend_ff;
        status[ST_HEAD_BIT +: QEIU_EV_W] = queue_ff[0];
    end

    // Capturing in setup keeps prdata steady through access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= RST_ZERO;
        end else if (setup) begin
            unique case (paddr)
                OFS_CTRL:      prdata_ff <= {31'h0000_0000, global_irq_enable_ff};
                OFS_EN_INPUT:  prdata_ff <= {24'h00_0000, en_input_ff};
                OFS_EN_MISC:   prdata_ff <= {27'h000_0000, en_misc_ff};
                OFS_EN_PULSE:  prdata_ff <= {24'h00_0000, en_pulse_ff};
                OFS_EN_SERIAL: prdata_ff <= {20'h0_0000, en_serial_ff};
                OFS_EN_POS:    prdata_ff <= {23'h00_0000, en_pos_ff};
                OFS_TMR0:      prdata_ff <= {16'h0000, interval_ff[0]};
                OFS_TMR1:      prdata_ff <= {16'h0000, interval_ff[1]};
                OFS_TMR2:      prdata_ff <= {16'h0000, interval_ff[2]};
                OFS_HND_LO:    prdata_ff <= handler_map_ff[31:0];
                OFS_HND_HI:    prdata_ff <= handler_map_ff[63:32];
                OFS_STATUS:    prdata_ff <= status;
                default:       prdata_ff <= RST_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------------
    // One divider feeds both the edge sampler and the timers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff <= RST_ZERO;
            tick_ff     <= 1'b0;
        end else if (tick_cnt_ff == 32'(TICK_DIV - 1)) begin
            tick_cnt_ff <= RST_ZERO;
            tick_ff     <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
            tick_ff     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Input edges, sampled once per millisecond
    // ------------------------------------------------------------------
    // Sampling on the tick bounds the edge rate; pulses shorter than a tick can be missed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ff <= RST_ZERO[7:0];
        end else if (tick_ff) begin
            pin_ff <= input_pins;
        end
    end

    assign rise = tick_ff ? (input_pins & ~pin_ff) : 8'h00;
    assign fall = tick_ff ? (~input_pins & pin_ff) : 8'h00;

    // ------------------------------------------------------------------
    // Periodic timers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_en_d_ff <= 3'h0;
        end else begin
            tmr_en_d_ff <= en_misc_ff[MISC_TMR_BIT +: 3];
        end
    end

    generate
        for (t = 0; t < 3; t++) begin : g_tmr
            logic en;
            assign en          = en_misc_ff[MISC_TMR_BIT + t];
            // A zero interval never fires, so an unset timer stays idle.
            assign tmr_fire[t] = en && tick_ff
                                 && interval_ff[t] != 16'h0000
                                 && elapsed_ff[t] + 16'h0001 >= interval_ff[t];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    elapsed_ff[t] <= 16'h0000;
                end else if (!en || (en && !tmr_en_d_ff[t])) begin
                    elapsed_ff[t] <= 16'h0000;
                end else if (tmr_fire[t]) begin
                    elapsed_ff[t] <= 16'h0000;
                end else if (tick_ff) begin
                    elapsed_ff[t] <= elapsed_ff[t] + 16'h0001;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Event vector and enable vector
    // ------------------------------------------------------------------
    always_comb begin
        raw_evt = {RST_ZERO, RST_ZERO};
        evt_en  = {RST_ZERO, RST_ZERO};

        for (int i = 0; i < 8; i++) begin
            raw_evt[EV_RISE_BASE + i] = rise[i];
            raw_evt[EV_FALL_BASE + i] = fall[i];
            evt_en[EV_RISE_BASE + i]  = en_input_ff[i];
            evt_en[EV_FALL_BASE + i]  = en_input_ff[i];
        end

        for (int i = 0; i < 6; i++) begin
            raw_evt[EV_CNT_LO_BASE + i] = counter_evt[i];
            evt_en[EV_CNT_LO_BASE + i]  = en_misc_ff[MISC_CNT_BIT];
            raw_evt[EV_POS_BASE + i]    = pass_pos_evt[i];
            evt_en[EV_POS_BASE + i]     = en_pos_ff[POS_PASS_BIT + i];
            raw_evt[EV_PULSE_HI + i]    = pulse_train_output_done[2 + i];
            evt_en[EV_PULSE_HI + i]     = en_pulse_ff[2 + i];
        end

        for (int i = 0; i < 2; i++) begin
            raw_evt[EV_CNT_HI_BASE + i] = counter_evt[6 + i];
            evt_en[EV_CNT_HI_BASE + i]  = en_misc_ff[MISC_CNT_BIT];
            raw_evt[EV_PULSE01 + i]     = pulse_train_output_done[i];
            evt_en[EV_PULSE01 + i]      = en_pulse_ff[i];
            raw_evt[EV_SER2_CHR + i]    = serial_evt[8 + i];
            evt_en[EV_SER2_CHR + i]     = en_serial_ff[8 + i];
            raw_evt[EV_SER2_FRM + i]    = serial_evt[10 + i];
            evt_en[EV_SER2_FRM + i]     = en_serial_ff[10 + i];
        end

        for (int i = 0; i < 8; i++) begin
            raw_evt[EV_SER01_BASE + i] = serial_evt[i];
            evt_en[EV_SER01_BASE + i]  = en_serial_ff[i];
        end

        for (int i = 0; i < 3; i++) begin
            raw_evt[EV_TIMER_BASE + i]  = tmr_fire[i];
            evt_en[EV_TIMER_BASE + i]   = en_misc_ff[MISC_TMR_BIT + i];
            raw_evt[EV_INTERP_BASE + i] = interp_done[i];
            evt_en[EV_INTERP_BASE + i]  = en_pos_ff[i];
        end

        raw_evt[EV_SUPPLY] = supply_fail;
        evt_en[EV_SUPPLY]  = en_misc_ff[MISC_SUP_BIT];
    end

    assign pend = (global_irq_enable_ff && !mask_ff)
                  ? (raw_evt & evt_en) : 64'h0;

    // ------------------------------------------------------------------
    // Request queue
    // ------------------------------------------------------------------
    // Unbound heads leave without waiting for the engine.
    assign deq = (count_ff != 4'h0)
                 && (handler_done || !handler_map_ff[queue_ff[0]]);

    // Enqueue only ever appends; disabling a source never touches stored entries.
    // Dequeue first, so a slot freed this cycle can take an event.
    always_comb begin
        nxt_count = count_ff;
        for (int k = 0; k < QEIU_DEPTH; k++) begin
            nxt_queue[k] = queue_ff[k];
        end

        if (deq) begin
            for (int k = 0; k < QEIU_DEPTH - 1; k++) begin
                nxt_queue[k] = queue_ff[k + 1];
            end
            nxt_queue[QEIU_DEPTH - 1] = 6'h00;
            nxt_count = count_ff - 4'h1;
        end

        for (int i = 0; i < QEIU_EV_NUM; i++) begin
            if (pend[i] && nxt_count < 4'(QEIU_DEPTH)) begin
                nxt_queue[nxt_count[2:0]] = 6'(i);
                nxt_count = nxt_count + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= 4'h0;
            for (int k = 0; k < QEIU_DEPTH; k++) begin
                queue_ff[k] <= 6'h00;
            end
        end else begin
            count_ff <= nxt_count;
            for (int k = 0; k < QEIU_DEPTH; k++) begin
                queue_ff[k] <= nxt_queue[k];
            end
        end
    end

    // ------------------------------------------------------------------
    // Mask and suspend
    // ------------------------------------------------------------------
    // The mask lifts only once the queue is empty and the main program has been resumed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= 1'b0;
        end else if (nxt_count == 4'(QEIU_DEPTH)) begin
            mask_ff <= 1'b1;
        end else if (count_ff == 4'h0 && !suspend_ff) begin
            mask_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            suspend_ff <= 1'b0;
        end else begin
            suspend_ff <= nxt_count != 4'h0;
        end
    end

    assign main_suspend     = suspend_ff;
    assign head_valid       = suspend_ff;

    assign head_event       = queue_ff[0];
    assign head_has_handler = suspend_ff && handler_map_ff[queue_ff[0]];

endmodule

// ---- testbench/qeiu_checker.sv ----
`timescale 1ns/10ps
module qeiu_checker
    import qeiu_pkg::*;
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 handler_done,
    input wire logic                 main_suspend,
    input wire logic                 head_valid,
    input wire logic [QEIU_EV_W-1:0] head_event,
    input wire logic                 head_has_handler
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_waiting;
        head_has_handler && !handler_done;
    endsequence
    sequence s_moved;
        head_valid && $past(head_valid) && $changed(head_event);
    endsequence

    a_suspend_head: assert property (main_suspend == head_valid)
        else $error("suspend and head valid differ");
    a_handler_valid: assert property (head_has_handler |-> head_valid)
        else $error("handler flag without head");
    a_head_hold: assert property (s_waiting |=> head_valid && $stable(head_event))
        else $error("head moved while in service");
    a_advance_cause: assert property (s_moved |-> $past(handler_done || !head_has_handler))
        else $error("head advanced without completion");
    a_resume_cause: assert property ($fell(main_suspend) |-> $past(handler_done || !head_has_handler))
        else $error("main resumed without completion");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access phase not ready");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    a_status_ro: assert property (psel && penable && pwrite && paddr == OFS_STATUS |-> pslverr)
        else $error("status write not refused");
    a_ctrl_ok: assert property (psel && penable && paddr == OFS_CTRL |-> !pslverr)
        else $error("control access refused");
endmodule

bind qeiu_top qeiu_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .handler_done(handler_done), .main_suspend(main_suspend), .head_valid(head_valid),
    .head_event(head_event), .head_has_handler(head_has_handler));

// ---- testbench/qeiu_engine.sv ----
`timescale 1ns/10ps
module qeiu_engine #(
    parameter int LAT = 3
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic head_has_handler,
    input  wire logic stall,
    output logic      handler_done
);
    // ----------------------------------------------------------------
    // Handler run time
    // ----------------------------------------------------------------
    // Stall lets the queue fill, as a long handler would.
    int cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff       <= 0;
            handler_done <= 1'b0;
        end else if (handler_done) begin
            handler_done <= 1'b0;
            cnt_ff       <= 0;
        end else if (head_has_handler && !stall) begin
            if (cnt_ff == LAT) begin
                handler_done <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + 1;
            end
        end else begin
            cnt_ff <= 0;
        end
    end
endmodule

// ---- testbench/queued_event_interrupt_unit_test.sv ----
`timescale 1ns/10ps
module queued_event_interrupt_unit_test;
    import qeiu_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, supply_fail, stall, err;
    logic        pready, pslverr, handler_done, main_suspend, head_valid, head_has_handler;
    logic [7:0]  paddr, input_pins, counter_evt, pulse_train_output_done;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] serial_evt;
    logic [2:0]  interp_done;
    logic [5:0]  pass_pos_evt, head_event;
    logic [5:0]  exp_q[$];
    int          error_cnt, cmp_count;

    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end

    qeiu_top #(.TICK_DIV(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .input_pins(input_pins), .counter_evt(counter_evt),
        .pulse_train_output_done(pulse_train_output_done), .serial_evt(serial_evt),
        .interp_done(interp_done), .pass_pos_evt(pass_pos_evt), .supply_fail(supply_fail),
        .handler_done(handler_done), .main_suspend(main_suspend), .head_valid(head_valid),
        .head_event(head_event), .head_has_handler(head_has_handler));
    qeiu_engine #(.LAT(3)) u_eng (.pclk(pclk), .presetn(presetn),
        .head_has_handler(head_has_handler), .stall(stall), .handler_done(handler_done));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_head(input logic [5:0] e);
        for (int i = 0; i < 200 && head_valid !== 1'b1; i++) @(posedge pclk);
        chk("head_event", e, head_event);
    endtask
    // Lets the engine run until the queue is empty, then stalls it again.
    task drain;
        stall <= 1'b0;
        for (int i = 0; i < 500 && main_suspend !== 1'b0; i++) @(posedge pclk);
        chk("main_suspend", 0, main_suspend);
        stall <= 1'b1;
    endtask
    task results;
        if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Checks the order in which bound handlers are served.
    always @(posedge pclk) begin
        if (handler_done === 1'b1 && head_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("served", 6'h3f, head_event);
            else chk("served", exp_q.pop_front(), head_event);
        end
    end

    initial begin
        #100000;
        error_cnt++;
        results;
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, input_pins, supply_fail} = '0;
        {counter_evt, pulse_train_output_done, serial_evt, interp_done, pass_pos_evt} = '0;
        stall = 1'b1;
        error_cnt = 0;
        cmp_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        xfer(0, OFS_STATUS, 0);
        chk("status", 0, rd);
        xfer(0, 8'h30, 0);
        chk("unmapped_err", 1, err);
        xfer(1, OFS_STATUS, 32'h1);
        chk("status_err", 1, err);
        xfer(1, OFS_EN_MISC, 32'h1);
        xfer(1, OFS_EN_SERIAL, 32'h1);
        @(posedge pclk);
        counter_evt <= 8'h01;
        @(posedge pclk);
        counter_evt <= 8'h00;
        xfer(0, OFS_STATUS, 0);
        chk("status", 0, rd);
        xfer(1, OFS_CTRL, 32'h1);
        xfer(1, OFS_HND_LO, 32'hffdf_ffff);
        xfer(1, OFS_HND_HI, 32'hffff_ffff);
        exp_q = '{6'd20, 6'd30, 6'd40};
        @(posedge pclk);
        counter_evt <= 8'h41;
        serial_evt  <= 12'h001;
        @(posedge pclk);
        counter_evt <= 8'h02;
        serial_evt  <= 12'h000;
        repeat (6) @(posedge pclk);
        counter_evt <= 8'h00;
        xfer(0, OFS_STATUS, 0);
        chk("status", 32'h1438, rd);
        drain;
        xfer(0, OFS_STATUS, 0);
        chk("status", 0, rd);
        exp_q = '{6'd20};
        @(posedge pclk);
        counter_evt <= 8'h01;
        @(posedge pclk);
        counter_evt <= 8'h00;
        xfer(0, OFS_STATUS, 0);
        chk("status", 32'h1421, rd);
        drain;
        for (int t = 0; t < 3; t++) begin
            exp_q = '{6'(26 + t)};
            xfer(1, OFS_TMR0 + 8'(4 * t), 32'd5);
            xfer(1, OFS_EN_MISC, 32'h1 | (32'h2 << t));
            wait_head(6'(26 + t));
            xfer(1, OFS_EN_MISC, 32'h1);
            xfer(0, OFS_STATUS, 0);
            chk("status", 32'h21 | (32'(26 + t) << 8), rd);
            drain;
        end
        xfer(1, OFS_HND_LO, 32'hffdf_dfff);
        xfer(1, OFS_EN_INPUT, 32'h08);
        exp_q = '{6'd3};
        input_pins <= 8'h08;
        wait_head(6'd3);
        drain;
        input_pins <= 8'h00;
        wait_head(6'd13);
        drain;
        xfer(1, OFS_EN_MISC, 32'h11);
        xfer(1, OFS_EN_PULSE, 32'h04);
        xfer(1, OFS_EN_POS, 32'h101);
        exp_q = '{6'd29, 6'd42, 6'd50, 6'd58};
        @(posedge pclk);
        {supply_fail, pulse_train_output_done, interp_done, pass_pos_evt} <= {1'b1, 8'h04, 3'h1, 6'h20};
        @(posedge pclk);
        {supply_fail, pulse_train_output_done, interp_done, pass_pos_evt} <= '0;
        wait_head(6'd29);
        drain;
        chk("pending", 0, exp_q.size());
        results;
    end
endmodule
